// *** core/cam_pkg.sv ***
package cam_pkg;
	localparam int NCELL = 6;
	localparam int NCHAN = 8;
	localparam int CH_AUX = 6;
	localparam int CH_TEMP = 7;
	localparam int CLK_MHZ = 20;
	// Conversion times per decimation code, microseconds
	localparam int CONV_US_0 = 214;
	localparam int CONV_US_1 = 311;
	localparam int CONV_US_2 = 503;
	localparam int CONV_US_3 = 887;
	localparam int CONV_CYC_0 = CONV_US_0 * CLK_MHZ;
	localparam int CONV_CYC_1 = CONV_US_1 * CLK_MHZ;
	localparam int CONV_CYC_2 = CONV_US_2 * CLK_MHZ;
	localparam int CONV_CYC_3 = CONV_US_3 * CLK_MHZ;
	localparam logic [1:0] DR_32 = 2'h0;
	localparam logic [1:0] DR_64 = 2'h1;
	localparam logic [1:0] DR_128 = 2'h2;
	localparam logic [1:0] DR_256 = 2'h3;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CELL_CONF = 8'h04;
	localparam logic [7:0] OFS_AUX_CONF = 8'h08;
	localparam logic [7:0] OFS_OW_CTRL = 8'h0C;
	localparam logic [7:0] OFS_CORR_GAIN = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_CORR_BASE = 8'h20;
	localparam logic [7:0] OFS_RAW_BASE = 8'h40;
	localparam logic [7:0] OFS_FILT_BASE = 8'h60;
	// Field positions
	localparam int POS_CONT = 8;
	localparam int POS_AUX_EN = 9;
	localparam int POS_GO = 16;
	localparam int POS_HOLD = 24;
	localparam int POS_FILSHIFT = 4;
	localparam int POS_AUX_SEL = 4;
	localparam int POS_AUX_CELL = 12;
	// Reset and stuck-value markers
	localparam logic [15:0] GAIN_RESET = 16'h8000;
	localparam logic [15:0] MARK16 = 16'h8000;
	localparam logic [23:0] MARK24 = 24'h800000;
	localparam int GAIN_SHIFT = 15;

	typedef enum logic [4:0] {
		AUX_CELL = 5'h00, AUX_STACK = 5'h01, AUX_ZERO = 5'h02, AUX_REF_SEC = 5'h03,
		AUX_REF_TER = 5'h04, AUX_ANALOG_RAIL = 5'h05, AUX_DIGITAL_RAIL = 5'h06,
		AUX_GP1 = 5'h07, AUX_GP2 = 5'h08, AUX_GP3 = 5'h09, AUX_GP4 = 5'h0A,
		AUX_GP5 = 5'h0B, AUX_GP6 = 5'h0C, AUX_OV_DAC = 5'h0D, AUX_UV_DAC = 5'h0E,
		AUX_OT_DAC = 5'h0F, AUX_UT_DAC = 5'h10, AUX_PTAT = 5'h11, AUX_TS_REF = 5'h12,
		AUX_XCVR = 5'h13, AUX_ALWAYS_ON = 5'h14
	} cam_aux_sel_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1, ST_CONV = 4'h2, ST_CORR = 4'h4, ST_PUSH = 4'h8
	} cam_state_t;

	typedef struct packed {
		logic [NCHAN-1:0] mask;
		logic [NCHAN-1:0][23:0] raw;
		logic [NCHAN-1:0][15:0] corr;
	} cam_snap_t;

	typedef struct packed {
		logic [NCELL-1:0] sink;
		logic source;
	} cam_ow_t;
endpackage

// *** core/cam_adc_chain.sv ***
// Notes on behaviour
// - Eight converter chains: six cells, one auxiliary, one die temperature.
// - Each cell has its own chain so all cells convert together.
// - All selected cells restart and capture on the same strobe: one snapshot.
// - Single conversion on go, or continuous; any subset of cells.
// - Each chain consumes a one-bit density stream from its modulator.
// - Order: input filter, modulator, third-order CIC, then low-pass.
// - Higher decimation narrows passband and lengthens conversion.
// - Reference gain correction follows CIC and is inside conversion time.
// - Raw uncorrected results stay readable beside corrected ones.
// - Separate decimation fields for cell and auxiliary converters.
// - Temperature converter uses the cell decimation setting.
// - Code 00 is ratio 32, 214 us; code 01 is ratio 64, 311 us.
// - Code 10 is ratio 128, about 503 us.
// - Auxiliary selector covers cell, stack, references, rails, inputs, DACs.
// - Writable control drives sinks on inputs one to six, source on zero.
// - No internal pin comparison; host judges open wire from results.
`timescale 1ns/10ps
module cam_cic
	import cam_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic strobe,
	input wire logic bitIn,
	input wire logic [1:0] drCode,
	output logic [23:0] result,
	output logic settled
);
	logic signed [25:0] integ0, integ1, integ2, dly0, dly1, dly2;
	logic signed [25:0] comb1, comb2, comb3, scaled;
	logic [7:0] phase, lastPhase;
	logic [1:0] outCount;
	logic signed [25:0] step;

	assign step = bitIn ? 26'sh0000001 : -26'sh0000001;
	assign lastPhase = 8'((32 << drCode) - 1);

	always_comb begin
		comb1 = integ2 - dly0;
		comb2 = comb1 - dly1;
		comb3 = comb2 - dly2;
		scaled = comb3 <<< (5'd3 * (5'd3 - {3'h0, drCode}));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			integ0 <= '0;
			integ1 <= '0;
			integ2 <= '0;
			dly0 <= '0;
			dly1 <= '0;
			dly2 <= '0;
			phase <= '0;
			outCount <= '0;
		end else if (clear) begin
			integ0 <= '0;
			integ1 <= '0;
			integ2 <= '0;
			dly0 <= '0;
			dly1 <= '0;
			dly2 <= '0;
			phase <= '0;
			outCount <= '0;
		end else if (strobe) begin
			integ0 <= integ0 + step;
			integ1 <= integ1 + integ0;
			integ2 <= integ2 + integ1;
			phase <= (phase == lastPhase) ? 8'h00 : phase + 8'h01;
			if (phase == lastPhase) begin
				dly0 <= integ2;
				dly1 <= comb1;
				dly2 <= comb2;
				if (outCount != 2'h3)
					outCount <= outCount + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			result <= MARK24;
		else if (strobe && !clear && phase == lastPhase)
			result <= (scaled >>> 1) > 26'sh07FFFFF ? 24'h7FFFFF : 24'((scaled >>> 1));
	end

	assign settled = (outCount == 2'h3);
endmodule

module cam_adc_chain
	import cam_pkg::*;
#(
	parameter int CONV_CYCLES_0 = CONV_CYC_0,
	parameter int CONV_CYCLES_1 = CONV_CYC_1,
	parameter int CONV_CYCLES_2 = CONV_CYC_2,
	parameter int CONV_CYCLES_3 = CONV_CYC_3,
	parameter int FIFO_DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [NCHAN-1:0] modBits,
	input wire logic modStrobe,
	output logic [NCELL-1:0] cellChannelEnable,
	output logic auxChannelEnable,
	output cam_aux_sel_t auxInputSelect,
	output logic [2:0] auxCellSelect,
	output cam_ow_t openWireCurrent,
	output logic busy
);
	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

	logic [NCELL-1:0] cellEnable;
	logic continuous, auxEnable, hold, goPulse;
	logic [1:0] cellDr, auxDr;
	logic [2:0] filShift;
	cam_aux_sel_t auxSel;
	logic [2:0] auxCell;
	cam_ow_t owCtrl;
	logic [15:0] corrGain;
	logic [7:0] convCount;

	logic dataPhase, dataWrite, readWait;
	logic [7:0] dataAddr;
	logic [31:0] readValue;
	logic wrStrobe;

	cam_state_t state;
	logic [15:0] timer, target;
	logic [2:0] corrIdx;
	logic [NCHAN-1:0] chanMask, chanSettled, cicClear;
	logic [NCHAN-1:0][23:0] cicResult;
	logic [1:0] chanDr [NCHAN];
	cam_snap_t snap;
	logic signed [40:0] product;

	cam_snap_t fifoMem [FIFO_DEPTH];
	logic [PW-1:0] wrPtr, rdPtr;
	logic [PW:0] fifoCount;
	logic pushValid, pushReady, popValid, popReady;

	logic [NCHAN-1:0][15:0] resCorr, resFilt;
	logic [NCHAN-1:0][23:0] resRaw;

	// Bus slave: writes zero wait, reads one wait state
	assign wrStrobe = dataPhase && dataWrite;
	assign hreadyout = !readWait;
	assign hresp = 1'b0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dataPhase <= 1'b0;
			dataWrite <= 1'b0;
			dataAddr <= '0;
			readWait <= 1'b0;
		end else if (hready) begin
			dataPhase <= hsel && htrans[1];
			dataWrite <= hwrite;
			dataAddr <= haddr[7:0];
			readWait <= hsel && htrans[1] && !hwrite;
		end else begin
			readWait <= 1'b0;
		end
	end

	always_comb begin
		readValue = 32'h00000000;
		case (dataAddr)
			OFS_CTRL: readValue = {7'h00, hold, 14'h0000, auxEnable, continuous, 2'h0, cellEnable};
			OFS_CELL_CONF: readValue = {25'h0, filShift, 2'h0, cellDr};
			OFS_AUX_CONF: readValue = {17'h0, auxCell, 3'h0, auxSel, 2'h0, auxDr};
			OFS_OW_CTRL: readValue = {25'h0, owCtrl};
			OFS_CORR_GAIN: readValue = {16'h0000, corrGain};
			OFS_STATUS: readValue = {16'h0000, convCount, 4'h0, state};
			default: begin
				if (dataAddr[7:5] == OFS_CORR_BASE[7:5] && dataAddr[1:0] == 2'h0)
					readValue = {16'h0000, resCorr[dataAddr[4:2]]};
				else if (dataAddr[7:5] == OFS_RAW_BASE[7:5] && dataAddr[1:0] == 2'h0)
					readValue = {8'h00, resRaw[dataAddr[4:2]]};
				else if (dataAddr[7:5] == OFS_FILT_BASE[7:5] && dataAddr[1:0] == 2'h0)
					readValue = {16'h0000, resFilt[dataAddr[4:2]]};
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			hrdata <= 32'h00000000;
		else if (readWait)
			hrdata <= readValue;
	end

	// Control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cellEnable <= '0;
			continuous <= 1'b0;
			auxEnable <= 1'b0;
			hold <= 1'b0;
			goPulse <= 1'b0;
			cellDr <= DR_32;
			filShift <= '0;
			auxDr <= DR_32;
			auxSel <= AUX_CELL;
			auxCell <= '0;
			owCtrl <= '0;
			corrGain <= GAIN_RESET;
		end else begin
			goPulse <= wrStrobe && dataAddr == OFS_CTRL && hwdata[POS_GO];
			if (wrStrobe) begin
				case (dataAddr)
					OFS_CTRL: begin
						cellEnable <= hwdata[NCELL-1:0];
						continuous <= hwdata[POS_CONT];
						auxEnable <= hwdata[POS_AUX_EN];
						hold <= hwdata[POS_HOLD];
					end
					OFS_CELL_CONF: begin
						cellDr <= hwdata[1:0];
						filShift <= hwdata[POS_FILSHIFT +: 3];
					end
					OFS_AUX_CONF: begin
						auxDr <= hwdata[1:0];
						auxSel <= cam_aux_sel_t'(hwdata[POS_AUX_SEL +: 5]);
						auxCell <= hwdata[POS_AUX_CELL +: 3];
					end
					OFS_OW_CTRL: owCtrl <= hwdata[NCELL:0];
					OFS_CORR_GAIN: corrGain <= hwdata[15:0];
					default: begin
					end
				endcase
			end
		end
	end

	assign cellChannelEnable = cellEnable;
	assign auxChannelEnable = auxEnable;
	assign auxInputSelect = auxSel;
	assign auxCellSelect = auxCell;
	assign openWireCurrent = owCtrl;
	assign busy = (state != ST_IDLE);

	// Converter chains
	assign chanMask = {1'b1, auxEnable, cellEnable};
	genvar g;
	generate
		for (g = 0; g < NCHAN; g++) begin : gChan
			assign chanDr[g] = (g == CH_AUX) ? auxDr : cellDr;
			assign cicClear[g] = (state != ST_CONV) || !chanMask[g];
			cam_cic uCic (
				.clk(clk),
				.rst(rst),
				.clear(cicClear[g]),
				.strobe(modStrobe),
				.bitIn(modBits[g]),
				.drCode(chanDr[g]),
				.result(cicResult[g]),
				.settled(chanSettled[g])
			);
		end
	endgenerate

	always_comb begin
		case (cellDr)
			DR_32: target = 16'(CONV_CYCLES_0);
			DR_64: target = 16'(CONV_CYCLES_1);
			DR_128: target = 16'(CONV_CYCLES_2);
			default: target = 16'(CONV_CYCLES_3);
		endcase
	end

	assign product = $signed(snap.raw[corrIdx]) * $signed({1'b0, corrGain});
	assign pushValid = (state == ST_PUSH);

	// Sequencer: conversion, correction, hand-off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			timer <= '0;
			corrIdx <= '0;
			snap <= '0;
			convCount <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					timer <= '0;
					if (goPulse)
						state <= ST_CONV;
				end
				ST_CONV: begin
					if (timer != 16'hFFFF)
						timer <= timer + 16'h0001;
					if (&(chanSettled | ~chanMask)) begin
						snap.mask <= chanMask;
						snap.raw <= cicResult;
						corrIdx <= '0;
						state <= ST_CORR;
					end
				end
				ST_CORR: begin
					timer <= (timer == 16'hFFFF) ? timer : timer + 16'h0001;
					snap.corr[corrIdx] <= product[GAIN_SHIFT + 23 -: 16];
					corrIdx <= corrIdx + 3'h1;
					if (corrIdx == 3'(NCHAN - 1))
						state <= ST_PUSH;
				end
				ST_PUSH: begin
					if (timer < target)
						timer <= timer + 16'h0001;
					else if (pushReady) begin
						convCount <= convCount + 8'h01;
						timer <= '0;
						state <= continuous ? ST_CONV : ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Snapshot buffer between sequencer and result registers
	assign pushReady = (fifoCount != (PW+1)'(FIFO_DEPTH)) && (timer >= target);
	assign popValid = (fifoCount != '0);
	assign popReady = !hold;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			fifoCount <= '0;
		end else if (goPulse && state == ST_IDLE) begin
			wrPtr <= '0;
			rdPtr <= '0;
			fifoCount <= '0;
		end else begin
			if (pushValid && pushReady)
				wrPtr <= (wrPtr == PW'(FIFO_DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			if (popValid && popReady)
				rdPtr <= (rdPtr == PW'(FIFO_DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			if ((pushValid && pushReady) && !(popValid && popReady))
				fifoCount <= fifoCount + 1'b1;
			else if (!(pushValid && pushReady) && (popValid && popReady))
				fifoCount <= fifoCount - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (pushValid && pushReady)
			fifoMem[wrPtr] <= snap;
	end

	// Result registers and single-pole low-pass
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			resCorr <= {NCHAN{MARK16}};
			resRaw <= {NCHAN{MARK24}};
			resFilt <= '0;
		end else if (goPulse && state == ST_IDLE) begin
			resCorr <= {NCHAN{MARK16}};
			resRaw <= {NCHAN{MARK24}};
		end else if (popValid && popReady) begin
			for (int i = 0; i < NCHAN; i++) begin
				if (fifoMem[rdPtr].mask[i]) begin
					resCorr[i] <= fifoMem[rdPtr].corr[i];
					resRaw[i] <= fifoMem[rdPtr].raw[i];
					resFilt[i] <= resFilt[i] + 16'(($signed({fifoMem[rdPtr].corr[i][15],
						fifoMem[rdPtr].corr[i]}) - $signed({resFilt[i][15], resFilt[i]}))
						>>> filShift);
				end
			end
		end
	end
endmodule

// *** tb/cam_adc_chain_monitor.sv ***
`timescale 1ns/10ps
module cam_adc_chain_monitor
	import cam_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [NCELL-1:0] cellChannelEnable,
	input wire cam_aux_sel_t auxInputSelect,
	input wire cam_ow_t openWireCurrent,
	input wire logic busy
);
	logic apWr;
	logic apRd;
	logic [7:0] apAddr;
	logic [2:0] goAge;
	// Data phase tracking
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			apWr <= 1'b0;
			apRd <= 1'b0;
			apAddr <= 8'h00;
		end else begin
			apWr <= hready && hsel && htrans[1] && hwrite;
			apRd <= hready && hsel && htrans[1] && !hwrite;
			if (hready && hsel && htrans[1]) begin
				apAddr <= haddr[7:0];
			end
		end
	end
	// Cycles since the last start command
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			goAge <= 3'h7;
		end else if (apWr && apAddr == OFS_CTRL && hwdata[POS_GO]) begin
			goAge <= 3'h0;
		end else if (goAge != 3'h7) begin
			goAge <= goAge + 3'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	okay_resp_a: assert property (hresp == 1'b0) else $error("bad hresp");
	write_no_wait_a: assert property (apWr |-> hreadyout) else $error("write waited");
	read_one_wait_a: assert property (apRd |-> !hreadyout ##1 hreadyout) else $error("read wait");
	ready_low_cause_a: assert property (!hreadyout |-> apRd) else $error("stray wait");
	ow_value_a: assert property (apWr && apAddr == OFS_OW_CTRL |=>
		openWireCurrent == $past(hwdata[6:0])) else $error("open wire value");
	ow_write_only_a: assert property ($changed(openWireCurrent) |->
		$past(apWr) && $past(apAddr) == OFS_OW_CTRL) else $error("open wire moved");
	enable_write_only_a: assert property ($changed(cellChannelEnable) |->
		$past(apWr) && $past(apAddr) == OFS_CTRL) else $error("enable moved");
	aux_sel_write_a: assert property (apWr && apAddr == OFS_AUX_CONF |=>
		auxInputSelect == $past(hwdata[8:4])) else $error("aux select");
	busy_go_start_a: assert property ($rose(busy) |-> goAge <= 3'h4) else $error("busy cause");
	busy_min_a: assert property ($rose(busy) |=> busy [*8]) else $error("busy short");
	cover property ($fell(busy));
	cover property (apRd);
	cover property (apWr && apAddr == OFS_OW_CTRL);
endmodule

bind cam_adc_chain cam_adc_chain_monitor i_mon (.clk(clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .cellChannelEnable(cellChannelEnable),
	.auxInputSelect(auxInputSelect), .openWireCurrent(openWireCurrent), .busy(busy));

// *** tb/cam_cell_model.sv ***
`timescale 1ns/10ps
module cam_cell_model
	import cam_pkg::*;
#(
	parameter int DIV = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] level,
	input wire cam_ow_t ow,
	output logic [NCHAN-1:0] modBits,
	output logic modStrobe
);
	logic [7:0] acc [NCHAN];
	int div;
	// Strobe once every DIV cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div <= 0;
			modStrobe <= 1'b0;
		end else begin
			div <= (div == DIV - 1) ? 0 : div + 1;
			modStrobe <= (div == 0);
		end
	end
	// One-bit density stream per channel; a sink pulls its cell low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			modBits <= '0;
			for (int i = 0; i < NCHAN; i++) acc[i] <= 8'h00;
		end else if (div == 0) begin
			for (int i = 0; i < NCHAN; i++) begin
				acc[i] <= acc[i] + level;
				modBits[i] <= ({1'b0, acc[i]} + {1'b0, level} > 9'h0FF) &&
					!(i < NCELL && ow.sink[3'(i % NCELL)]);
			end
		end
	end
endmodule

// *** tb/cam_adc_chain_tb.sv ***
`timescale 1ns/10ps
module cam_adc_chain_tb
	import cam_pkg::*;
;
	logic clk, rst, hsel, hwrite, hreadyout, hresp, modStrobe, auxEn, busy;
	logic [31:0] haddr, hwdata, hrdata, q0, q1;
	logic [1:0] htrans;
	logic [2:0] hsize, auxCell;
	logic [NCHAN-1:0] modBits;
	logic [NCELL-1:0] cellEn;
	cam_aux_sel_t auxSel;
	cam_ow_t ow;
	int errors, checks, n;
	cam_adc_chain #(.CONV_CYCLES_0(8), .CONV_CYCLES_1(8), .CONV_CYCLES_2(8),
		.CONV_CYCLES_3(8)) i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.modBits(modBits), .modStrobe(modStrobe), .cellChannelEnable(cellEn),
		.auxChannelEnable(auxEn), .auxInputSelect(auxSel), .auxCellSelect(auxCell),
		.openWireCurrent(ow), .busy(busy));
	cam_cell_model i_cells (.clk(clk), .rst(rst), .level(8'hC0), .ow(ow),
		.modBits(modBits), .modStrobe(modStrobe));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, e);
	endtask
	task automatic runIdle(output int c);
		c = 0;
		repeat (3) @(posedge clk);
		while (busy !== 1'b0) begin
			@(posedge clk);
			c++;
		end
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		end_of_test();
	end
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		errors = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdChk(OFS_CORR_GAIN, 32'h8000);
		rdChk(OFS_RAW_BASE, 32'h800000);
		rdChk(8'hFC, 32'h0);
		$display("reset test done");
		wr(OFS_OW_CTRL, 32'h7F);
		@(posedge clk);
		check(32'(ow), 32'h7F);
		rdChk(OFS_OW_CTRL, 32'h7F);
		wr(OFS_OW_CTRL, 32'h0);
		for (int s = 0; s <= 20; s++) begin
			wr(OFS_AUX_CONF, (32'(s) << 4) | 32'h5000);
			@(posedge clk);
			check(32'({auxCell, auxSel}), 32'(s) | 32'hA0);
			rdChk(OFS_AUX_CONF, (32'(s) << 4) | 32'h5000);
		end
		$display("register test done");
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CELL_CONF, 32'(c));
			rdChk(OFS_CELL_CONF, 32'(c));
			wr(OFS_CTRL, 32'h0001003F);
			@(posedge clk);
			check(32'(cellEn), 32'h3F);
			runIdle(n);
			check(32'(n >= 6 * (32 << c) - 8), 32'h1);
			check(32'(n < 6 * (32 << c) + 80), 32'h1);
			rd(OFS_RAW_BASE, q0);
			rd(OFS_CORR_BASE, q1);
			check(q1, {16'h0000, q0[23:8]});
			for (int ch = 1; ch < NCELL; ch++) rdChk(OFS_RAW_BASE + 8'(4 * ch), q0);
			rdChk(OFS_RAW_BASE + 8'h1C, q0);
			rd(OFS_CORR_BASE + 8'h1C, q1);
			check(32'(q1 !== 32'h8000), 32'h1);
			rdChk(OFS_CORR_BASE + 8'h18, 32'h8000);
		end
		$display("decimation test done");
		wr(OFS_CELL_CONF, 32'h0);
		wr(OFS_AUX_CONF, 32'h3);
		wr(OFS_CTRL, 32'h00010205);
		runIdle(n);
		check(32'(n >= 6 * 256 - 8), 32'h1);
		check(32'(auxEn), 32'h1);
		rd(OFS_RAW_BASE, q0);
		rdChk(OFS_RAW_BASE + 8'h1C, q0);
		rdChk(OFS_CORR_BASE + 8'h4, 32'h8000);
		rd(OFS_CORR_BASE + 8'h18, q1);
		check(32'(q1 !== 32'h8000), 32'h1);
		$display("subset test done");
		wr(OFS_OW_CTRL, 32'h2);
		repeat (200) @(posedge clk);
		wr(OFS_CTRL, 32'h00010003);
		runIdle(n);
		rd(OFS_RAW_BASE, q0);
		check(32'(q0[23]), 32'h1);
		rd(OFS_RAW_BASE + 8'h4, q1);
		check(32'(q1[23]), 32'h0);
		rd(OFS_FILT_BASE, q1);
		check(32'(q1[15]), 32'h1);
		$display("open wire test done");
		wr(OFS_OW_CTRL, 32'h0);
		wr(OFS_CTRL, 32'h0101013F);
		rdChk(OFS_CTRL, 32'h0100013F);
		repeat (2000) @(posedge clk);
		check(32'(busy), 32'h1);
		rdChk(OFS_CORR_BASE, 32'h8000);
		wr(OFS_CTRL, 32'h0000003F);
		runIdle(n);
		rd(OFS_CORR_BASE, q1);
		check(32'(q1 !== 32'h8000), 32'h1);
		rdChk(OFS_STATUS, 32'h00000901);
		$display("buffer test done");
		end_of_test();
	end
endmodule
